//--- include/slrf_map.vh
// register map, field positions, reset values and format codes of the sensor log record formatter
`ifndef SLRF_MAP_VH
`define SLRF_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SLRF_OFF_CFG 12'h000
`define SLRF_OFF_LIM_LO 12'h004
`define SLRF_OFF_LIM_HI 12'h008
`define SLRF_OFF_STATUS 12'h00c

// ----------------------------------------
// configuration fields
// ----------------------------------------
`define SLRF_CFG_FMT_LSB 0
`define SLRF_CFG_LCS_LSB 3
`define SLRF_CFG_BATT_BIT 5
`define SLRF_CFG_EXT_SENSOR_INPUT_ONE_BIT 6
`define SLRF_CFG_EXT_SENSOR_INPUT_TWO_BIT 7
`define SLRF_CFG_RST 8'h00
`define SLRF_LIM_LO_RST 10'h000
`define SLRF_LIM_HI_RST 10'h3ff

// ----------------------------------------
// status fields
// ----------------------------------------
`define SLRF_ST_LVL_LSB 16
`define SLRF_ST_BUSY_BIT 24

// ----------------------------------------
// logging format select codes
// ----------------------------------------
`define SLRF_FMT_DENSE 3'h0
`define SLRF_FMT_ALL_OUT 3'h1
`define SLRF_FMT_CROSS 3'h3
`define SLRF_FMT_IRQ1 3'h5
`define SLRF_FMT_IRQ2 3'h6
`define SLRF_FMT_IRQ12 3'h7

// ----------------------------------------
// limit-check sensor codes
// ----------------------------------------
`define SLRF_LCS_TEMP 2'h0
`define SLRF_LCS_EXT_SENSOR_INPUT_ONE 2'h1
`define SLRF_LCS_EXT_SENSOR_INPUT_TWO 2'h2
`define SLRF_LCS_BATT 2'h3

`endif

//--- logic/slrf_formatter.v
// sensor log record formatter with apb registers and an output word fifo
// Behaviour
// (RULE_01) a three-bit format select field in the config register picks the record format
// (RULE_02) format zero stores every sample with no time information
// (RULE_03) format one stores only samples outside the limits
// (RULE_04) limit comparison uses only the sensor named by the two-bit select
// (RULE_05) limit formats add the running measurement number to each record
// (RULE_06) format three writes a record only where a limit boundary is crossed
// (RULE_07) software never programs the reserved format codes 010 and 100
// (RULE_08) codes 101, 110, 111 log on external input one, two, or either
// (RULE_09) dense temperature-only packs eight 10-bit values into five words
// (RULE_10) battery/temperature word: battery in bits 15..10, temperature in 9..0
// (RULE_11) external word: value in 9..0, range in 14..10
// (RULE_12) one external sensor: external word first, then battery/temperature word
// (RULE_13) two external sensors: ext one, ext two, then battery/temperature word
// (RULE_14) packed values run msb first, continuing across word boundaries
// (RULE_15) don't-care bit 15 and unused fields are written as zero
// (RULE_16) both limit formats use one layout: sensor words then measurement number
// (RULE_17) interrupt formats append rtc high then low half and ignore limits
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "slrf_map.vh"

// ----------------------------------------
// word fifo
// ----------------------------------------
module slrf_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk, // system clock
  input wire sys_rst, // synchronous reset, high
  input wire ce, // clock enable
  input wire in_valid, // write request
  output wire in_ready, // room available
  input wire [WIDTH-1:0] in_data, // write word
  output wire out_valid, // word available
  input wire out_ready, // reader takes word
  output wire [WIDTH-1:0] out_data, // head word
  output wire [AW:0] level // words held
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r, rp_r;
  reg [AW:0] cnt_r;
  wire push, pop;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  assign level = cnt_r;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointers wrap at depth so depth need not be a power of two
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop)
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // slrf_fifo

// ----------------------------------------
// formatter top
// ----------------------------------------
module slrf_formatter #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire sys_clk, // system clock, 10 MHz
  input wire sys_rst, // synchronous reset, high
  input wire ce, // clock enable, freezes all state when low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready, always high
  output wire [31:0] prdata, // apb read data
  output wire pslverr, // apb error on unmapped address
  input wire smp_valid, // one measurement offered
  output wire smp_ready, // formatter idle, takes measurement
  input wire [9:0] smp_temp, // temperature value
  input wire [5:0] smp_batt, // battery result
  input wire [9:0] smp_ext_sensor_input_one, // ext_sensor_input_one value
  input wire [4:0] smp_ext_sensor_input_one_rng, // ext_sensor_input_one range
  input wire [9:0] smp_ext_sensor_input_two, // ext_sensor_input_two value
  input wire [4:0] smp_ext_sensor_input_two_rng, // ext_sensor_input_two range
  input wire smp_irq1, // ext_sensor_input_one interrupt caused sample
  input wire smp_irq2, // ext_sensor_input_two interrupt caused sample
  input wire [31:0] rtc, // real-time clock value
  output wire mem_valid, // word for the measurement area
  input wire mem_ready, // measurement area takes word
  output wire [15:0] mem_data // record word
);
  localparam ST_IDLE = 2'b01;
  localparam ST_EMIT = 2'b10;

  reg [7:0] cfg_r;
  reg [9:0] lim_lo_r, lim_hi_r;
  reg [31:0] prdata_r;
  reg [1:0] state_r;
  reg [15:0] rec_r [0:4];
  reg [2:0] rec_n_r, rec_i_r;
  reg [15:0] meas_r;
  reg prev_out_r, cfg_wr, map_hit, out_now, store;
  reg [14:0] pend_r;
  reg [3:0] pbits_r;
  reg [31:0] rd_val;
  reg [9:0] chk_val;
  reg [2:0] n;
  reg [15:0] w0, w1, w2, w3, w4;
  reg [24:0] cat;
  reg [4:0] cbits;
  wire [2:0] fmt;
  wire [1:0] lcs;
  wire temp_only, take, fifo_in_ready;
  wire [FIFO_AW:0] fifo_lvl;
  wire [15:0] bt_word;

  // external sensor word, bit 15 forced low
  function [15:0] ext_word;
    input [4:0] rng;
    input [9:0] val;
    begin
      ext_word = {1'b0, rng, val}; // see (RULE_11) see (RULE_15)
    end
  endfunction

  assign fmt = cfg_r[`SLRF_CFG_FMT_LSB+2:`SLRF_CFG_FMT_LSB]; // see (RULE_01)
  assign lcs = cfg_r[`SLRF_CFG_LCS_LSB+1:`SLRF_CFG_LCS_LSB];
  assign temp_only = ~cfg_r[`SLRF_CFG_BATT_BIT] & ~cfg_r[`SLRF_CFG_EXT_SENSOR_INPUT_ONE_BIT] & ~cfg_r[`SLRF_CFG_EXT_SENSOR_INPUT_TWO_BIT];
  // battery field left zero when battery logging is off
  assign bt_word = {cfg_r[`SLRF_CFG_BATT_BIT] ? smp_batt : 6'h00, smp_temp}; // see (RULE_10) see (RULE_15)
  assign smp_ready = state_r[0];
  assign take = smp_valid & state_r[0] & ce;

  // ----------------------------------------
  // apb slave, zero wait state
  // ----------------------------------------
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = psel & penable & ~map_hit;

  always @* begin
    map_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `SLRF_OFF_CFG: rd_val = {24'h00_0000, cfg_r};
      `SLRF_OFF_LIM_LO: rd_val = {22'h00_0000, lim_lo_r};
      `SLRF_OFF_LIM_HI: rd_val = {22'h00_0000, lim_hi_r};
      `SLRF_OFF_STATUS: begin
        rd_val[15:0] = meas_r;
        rd_val[`SLRF_ST_LVL_LSB+FIFO_AW:`SLRF_ST_LVL_LSB] = fifo_lvl;
        rd_val[`SLRF_ST_BUSY_BIT] = state_r[1];
      end
      default: map_hit = 1'b0;
    endcase
    cfg_wr = psel & penable & pwrite & (paddr == `SLRF_OFF_CFG);
  end

  // read data captured in the setup cycle so it is a flop at the access edge
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_r <= `SLRF_CFG_RST;
      lim_lo_r <= `SLRF_LIM_LO_RST;
      lim_hi_r <= `SLRF_LIM_HI_RST;
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      if (psel & ~penable)
        prdata_r <= rd_val;
      if (cfg_wr)
        cfg_r <= pwdata[7:0];
      if (psel & penable & pwrite & (paddr == `SLRF_OFF_LIM_LO))
        lim_lo_r <= pwdata[9:0];
      if (psel & penable & pwrite & (paddr == `SLRF_OFF_LIM_HI))
        lim_hi_r <= pwdata[9:0];
    end
  end

  // ----------------------------------------
  // record assembly
  // ----------------------------------------
  always @* begin
    case (lcs)
      `SLRF_LCS_TEMP: chk_val = smp_temp; // see (RULE_04)
      `SLRF_LCS_EXT_SENSOR_INPUT_ONE: chk_val = smp_ext_sensor_input_one;
      `SLRF_LCS_EXT_SENSOR_INPUT_TWO: chk_val = smp_ext_sensor_input_two;
      default: chk_val = {4'h0, smp_batt};
    endcase
    out_now = (chk_val < lim_lo_r) | (chk_val > lim_hi_r);
    case (fmt)
      `SLRF_FMT_DENSE: store = 1'b1; // see (RULE_02)
      `SLRF_FMT_ALL_OUT: store = out_now; // see (RULE_03)
      `SLRF_FMT_CROSS: store = out_now ^ prev_out_r; // see (RULE_06)
      `SLRF_FMT_IRQ1: store = smp_irq1; // see (RULE_08)
      `SLRF_FMT_IRQ2: store = smp_irq2;
      `SLRF_FMT_IRQ12: store = smp_irq1 | smp_irq2;
      default: store = 1'b0; // reserved codes log nothing, see (RULE_07)
    endcase
    // dense packing: pending bits right aligned, new value appended below them
    cat = {pend_r, smp_temp}; // see (RULE_14)
    cbits = {1'b0, pbits_r} + 5'h0a;
    // sensor words in fixed order, then the per-format trailer
    w0 = 16'h0000;
    w1 = 16'h0000;
    w2 = 16'h0000;
    w3 = 16'h0000;
    w4 = 16'h0000;
    n = 3'h0;
    if (cfg_r[`SLRF_CFG_EXT_SENSOR_INPUT_ONE_BIT] & cfg_r[`SLRF_CFG_EXT_SENSOR_INPUT_TWO_BIT]) begin
      w0 = ext_word(smp_ext_sensor_input_one_rng, smp_ext_sensor_input_one); // see (RULE_13)
      w1 = ext_word(smp_ext_sensor_input_two_rng, smp_ext_sensor_input_two);
      w2 = bt_word;
      n = 3'h3;
    end else if (cfg_r[`SLRF_CFG_EXT_SENSOR_INPUT_ONE_BIT] | cfg_r[`SLRF_CFG_EXT_SENSOR_INPUT_TWO_BIT]) begin
      w0 = cfg_r[`SLRF_CFG_EXT_SENSOR_INPUT_ONE_BIT] ? ext_word(smp_ext_sensor_input_one_rng, smp_ext_sensor_input_one) : ext_word(smp_ext_sensor_input_two_rng, smp_ext_sensor_input_two);
      w1 = bt_word; // see (RULE_12)
      n = 3'h2;
    end else begin
      w0 = bt_word;
      n = 3'h1;
    end
    if ((fmt == `SLRF_FMT_ALL_OUT) | (fmt == `SLRF_FMT_CROSS)) begin
      case (n)
        3'h1: w1 = meas_r; // see (RULE_05) see (RULE_16)
        3'h2: w2 = meas_r;
        default: w3 = meas_r;
      endcase
      n = n + 3'h1;
    end else if (fmt[2]) begin
      case (n)
        3'h1: begin
          w1 = rtc[31:16]; // see (RULE_17)
          w2 = rtc[15:0];
        end
        3'h2: begin
          w2 = rtc[31:16];
          w3 = rtc[15:0];
        end
        default: begin
          w3 = rtc[31:16];
          w4 = rtc[15:0];
        end
      endcase
      n = n + 3'h2;
    end
  end

  // ----------------------------------------
  // control: accept sample, then push record words
  // ----------------------------------------
  // the sample port stalls while a record drains, so fifo back-pressure reaches the source
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      rec_n_r <= 3'h0;
      rec_i_r <= 3'h0;
      meas_r <= 16'h0000;
      prev_out_r <= 1'b0;
      pend_r <= 15'h0000;
      pbits_r <= 4'h0;
    end else if (ce) begin
      if (cfg_wr) begin
        // a new format starts a fresh packing group and crossing history
        pend_r <= 15'h0000;
        pbits_r <= 4'h0;
        prev_out_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (take & ~cfg_wr) begin
            meas_r <= meas_r + 16'h0001;
            prev_out_r <= out_now;
            rec_i_r <= 3'h0;
            if ((fmt == `SLRF_FMT_DENSE) & temp_only) begin
              if (cbits >= 5'h10) begin
                rec_r[0] <= cat[cbits-5'h10 +: 16]; // see (RULE_09) see (RULE_14)
                pend_r <= cat[14:0] & ((15'h0001 << (cbits - 5'h10)) - 15'h0001);
                pbits_r <= cbits[3:0];
                rec_n_r <= 3'h1;
                state_r <= ST_EMIT;
              end else begin
                pend_r <= cat[14:0];
                pbits_r <= cbits[3:0];
              end
            end else if (store) begin
              rec_r[0] <= w0;
              rec_r[1] <= w1;
              rec_r[2] <= w2;
              rec_r[3] <= w3;
              rec_r[4] <= w4;
              rec_n_r <= n;
              state_r <= ST_EMIT;
            end
          end
        end
        ST_EMIT: begin
          if (fifo_in_ready) begin
            if (rec_i_r == rec_n_r - 3'h1)
              state_r <= ST_IDLE;
            rec_i_r <= rec_i_r + 3'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  slrf_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(state_r[1]),
    .in_ready(fifo_in_ready),
    .in_data(rec_r[rec_i_r]),
    .out_valid(mem_valid),
    .out_ready(mem_ready),
    .out_data(mem_data),
    .level(fifo_lvl)
  );
endmodule // slrf_formatter

//--- verification/slrf_formatter_checker.sv
// port-level assertions for the sensor log record formatter
`timescale 1ns/10ps
module slrf_formatter_checker (
  input wire sys_clk, // clock
  input wire sys_rst, // reset
  input wire ce, // enable
  input wire psel, // apb select
  input wire penable, // apb access
  input wire pwrite, // apb write
  input wire [11:0] paddr, // apb address
  input wire [31:0] pwdata, // apb wdata
  input wire pready, // apb ready
  input wire [31:0] prdata, // apb rdata
  input wire pslverr, // apb error
  input wire smp_valid, // sample offered
  input wire smp_ready, // sample taken
  input wire smp_irq1, // irq one
  input wire smp_irq2, // irq two
  input wire mem_valid, // word offered
  input wire mem_ready, // word taken
  input wire [15:0] mem_data // word
);
  reg [7:0] cfg_r; // shadow of the config register
  wire acc = psel && penable;
  wire cfg_wr = acc && pwrite && ce && paddr == 12'h000;
  wire take = smp_valid && smp_ready && ce && !cfg_wr;
  wire irq_fmt = cfg_r[2] && cfg_r[1:0] != 2'h0;
  wire irq_hit = (cfg_r[0] && smp_irq1) || (cfg_r[1] && smp_irq2);
  // shadow the format so mode-dependent checks know what to expect
  always @(posedge sys_clk) begin
    if (sys_rst)
      cfg_r <= 8'h00;
    else if (cfg_wr)
      cfg_r <= pwdata[7:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_unmapped_err: assert property (acc && paddr > 12'h00c |-> pslverr) else $error("no error on unmapped");
  a_mapped_ok: assert property (acc && paddr <= 12'h00c && paddr[1:0] == 2'h0 |-> pready && !pslverr)
    else $error("mapped access refused");
  a_cfg_readback: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata == {24'h0, cfg_r})
    else $error("config readback wrong");
  a_dense_stores: assert property (cfg_r[2:0] == 3'h0 && cfg_r[7:5] != 3'h0 && take |=> !smp_ready)
    else $error("dense sample not stored");
  a_irq_skip: assert property (irq_fmt && take && !irq_hit |=> smp_ready) else $error("record without irq");
  a_irq_store: assert property (irq_fmt && take && irq_hit |=> !smp_ready [*3])
    else $error("irq record too short");
  a_reserved_quiet: assert property ((cfg_r[2:0] == 3'h2 || cfg_r[2:0] == 3'h4) && take |=> smp_ready ##1 smp_ready)
    else $error("reserved code stored");
  a_head_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_data))
    else $error("word changed while held");
endmodule // slrf_formatter_checker

bind slrf_formatter slrf_formatter_checker i_slrf_formatter_checker (.sys_clk, .sys_rst, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .smp_valid, .smp_ready, .smp_irq1, .smp_irq2, .mem_valid,
  .mem_ready, .mem_data);

//--- verification/slrf_mem_model.sv
// measurement area model that stores record words, with stall and slow modes
`timescale 1ns/10ps
module slrf_mem_model (
  input wire sys_clk, // clock
  input wire sys_rst, // reset
  input wire stall, // hold off all words
  input wire slow, // take every other cycle
  input wire mem_valid, // word offered
  input wire [15:0] mem_data, // word
  output reg mem_ready // word taken
);
  logic [15:0] got[$]; // words in arrival order
  reg tick_r; // pace for slow mode
  // ready moves just after an edge; a word lands where valid meets ready
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      tick_r <= 1'b0;
      mem_ready <= 1'b0;
    end else begin
      if (mem_valid && mem_ready)
        got.push_back(mem_data);
      tick_r <= !tick_r;
      mem_ready <= !stall && (!slow || tick_r);
    end
  end
endmodule // slrf_mem_model

//--- verification/slrf_formatter_bench.sv
// self-checking bench for the sensor log record formatter
`timescale 1ns/10ps
module slrf_formatter_bench;
  reg sys_clk, sys_rst, ce, psel, penable, pwrite, smp_valid, smp_irq1, smp_irq2, stall, slow, er;
  reg [11:0] paddr;
  reg [31:0] pwdata, rtc, rd;
  reg [9:0] smp_temp, smp_ext_sensor_input_one, smp_ext_sensor_input_two;
  reg [5:0] smp_batt;
  reg [4:0] smp_ext_sensor_input_one_rng, smp_ext_sensor_input_two_rng;
  wire pready, pslverr, smp_ready, mem_valid, mem_ready;
  wire [31:0] prdata;
  wire [15:0] mem_data;
  logic [15:0] exp[$];
  integer fail_count, checked, n_meas;
  slrf_formatter i_slrf_formatter (.sys_clk, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .smp_valid, .smp_ready, .smp_temp, .smp_batt, .smp_ext_sensor_input_one, .smp_ext_sensor_input_one_rng, .smp_ext_sensor_input_two,
    .smp_ext_sensor_input_two_rng, .smp_irq1, .smp_irq2, .rtc, .mem_valid, .mem_ready, .mem_data);
  slrf_mem_model i_slrf_mem_model (.sys_clk, .sys_rst, .stall, .slow, .mem_valid, .mem_data, .mem_ready);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = !sys_clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task give_verdict;
    begin
      $display("checks %0d errors %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task oops(input string what);
    begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, what);
      give_verdict;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] want, input string what);
    begin
      checked++;
      if (got !== want) begin
        fail_count++;
        $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
      end
    end
  endtask
  // reads right after an edge see the values that edge sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
        if (n > 20)
          oops("apb hang");
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] want, input logic e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, want, "read data");
      chk({31'h0, er}, {31'h0, e}, "read error");
    end
  endtask
  // inputs stay put until the formatter takes the sample
  task smp(input logic [9:0] t, input logic [5:0] b, input logic i1, input logic i2);
    integer n;
    begin
      @(posedge sys_clk);
      smp_temp <= t;
      smp_batt <= b;
      smp_ext_sensor_input_one <= ~t;
      smp_ext_sensor_input_one_rng <= t[4:0];
      smp_ext_sensor_input_two <= t ^ 10'h2aa;
      smp_ext_sensor_input_two_rng <= ~t[4:0];
      smp_irq1 <= i1;
      smp_irq2 <= i2;
      rtc <= {n_meas[15:0], 6'h2a, t};
      smp_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
        if (n > 300)
          oops("sample hang");
      end while (smp_ready !== 1'b1);
      smp_valid <= 1'b0;
      n_meas++;
    end
  endtask
  // expected record for one sample, pushed before the sample goes in
  task put(input logic [7:0] c, input logic [9:0] t, input logic [5:0] b);
    begin
      if (c[6])
        exp.push_back({1'b0, t[4:0], ~t});
      if (c[7])
        exp.push_back({1'b0, ~t[4:0], t ^ 10'h2aa});
      exp.push_back({c[5] ? b : 6'h00, t});
      if (c[2:0] == 3'h1 || c[2:0] == 3'h3)
        exp.push_back(n_meas[15:0]);
      if (c[2]) begin
        exp.push_back(n_meas[15:0]);
        exp.push_back({6'h2a, t});
      end
    end
  endtask
  task match;
    integer n;
    begin
      n = 0;
      while (i_slrf_mem_model.got.size() < exp.size() && n < 600) begin
        @(posedge sys_clk);
        n++;
      end
      repeat (6) @(posedge sys_clk);
      if (n >= 600)
        oops("record hang");
      chk(i_slrf_mem_model.got.size(), exp.size(), "word count");
      foreach (exp[i])
        chk(i_slrf_mem_model.got[i], exp[i], "word");
      exp.delete();
      i_slrf_mem_model.got.delete();
    end
  endtask
  task do_reset;
    begin
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      n_meas = 0;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task s_regs;
    begin
      rdc(12'h000, 32'h0, 1'b0);
      rdc(12'h008, 32'h3ff, 1'b0);
      apb(1'b1, 12'h004, 32'hffff_f123);
      rdc(12'h004, 32'h123, 1'b0);
      apb(1'b1, 12'h00c, 32'hffff_ffff);
      rdc(12'h00c, {16'h0, n_meas[15:0]}, 1'b0);
      rdc(12'h010, 32'h0, 1'b1);
      apb(1'b1, 12'h000, 32'h1ff);
      rdc(12'h000, 32'hff, 1'b0);
      // a write while the clock enable is low must leave the limit untouched
      ce <= 1'b0;
      apb(1'b1, 12'h004, 32'h0);
      ce <= 1'b1;
      rdc(12'h004, 32'h123, 1'b0);
    end
  endtask
  task s_pack;
    logic [79:0] v;
    integer i;
    begin
      apb(1'b1, 12'h000, 32'h0);
      slow <= 1'b1;
      for (i = 0; i < 8; i++) begin
        v = {v[69:0], 10'h3a7 - 10'(i * 83)};
        smp(v[9:0], 6'h3f, 1'b0, 1'b0);
      end
      for (i = 0; i < 5; i++)
        exp.push_back(v[79 - 16 * i -: 16]);
      match;
      slow <= 1'b0;
    end
  endtask
  task s_dense;
    logic [7:0] ca[0:3] = '{8'h20, 8'h40, 8'h80, 8'he0};
    integer i;
    begin
      for (i = 0; i < 4; i++) begin
        apb(1'b1, 12'h000, {24'h0, ca[i]});
        put(ca[i], 10'h1c3 + 10'(i), 6'h2b);
        smp(10'h1c3 + 10'(i), 6'h2b, 1'b0, 1'b0);
      end
      match;
    end
  endtask
  task s_limit;
    logic [9:0] ta[0:3] = '{10'h0ff, 10'h100, 10'h200, 10'h201};
    logic [9:0] tb[0:3] = '{10'h2af, 10'h1af, 10'h19f, 10'h27f};
    integer i;
    begin
      apb(1'b1, 12'h004, 32'h100);
      apb(1'b1, 12'h008, 32'h200);
      apb(1'b1, 12'h000, 32'h01);
      for (i = 0; i < 4; i++) begin
        if (i == 0 || i == 3)
          put(8'h01, ta[i], 6'h15);
        smp(ta[i], 6'h15, 1'b0, 1'b0);
      end
      apb(1'b1, 12'h000, 32'h4b);
      for (i = 0; i < 4; i++) begin
        if (i == 1 || i == 3)
          put(8'h4b, tb[i], 6'h15);
        smp(tb[i], 6'h15, 1'b0, 1'b0);
      end
      match;
    end
  endtask
  task s_irq;
    integer f, k;
    begin
      for (f = 5; f < 8; f++) begin
        apb(1'b1, 12'h000, {24'h0, 5'h18, f[2:0]});
        for (k = 0; k < 3; k++) begin
          if ((k == 1 && f != 6) || (k == 2 && f != 5))
            put({5'h18, f[2:0]}, 10'h2d3 + 10'(k), 6'h2e);
          smp(10'h2d3 + 10'(k), 6'h2e, k == 1, k == 2);
        end
      end
      match;
    end
  endtask
  // the 17th word cannot enter a full fifo, so the formatter stays busy
  task s_fill;
    integer i;
    begin
      apb(1'b1, 12'h000, 32'h02);
      smp(10'h111, 6'h01, 1'b0, 1'b0);
      apb(1'b1, 12'h000, 32'h04);
      smp(10'h222, 6'h02, 1'b0, 1'b0);
      apb(1'b1, 12'h000, 32'h20);
      stall <= 1'b1;
      for (i = 0; i < 17; i++) begin
        put(8'h20, 10'h040 + 10'(i), 6'h3f - 6'(i));
        smp(10'h040 + 10'(i), 6'h3f - 6'(i), 1'b0, 1'b0);
      end
      rdc(12'h00c, {7'h0, 1'b1, 3'h0, 5'h10, n_meas[15:0]}, 1'b0);
      stall <= 1'b0;
      match;
      rdc(12'h00c, {16'h0, n_meas[15:0]}, 1'b0);
    end
  endtask
  initial begin
    {ce, psel, penable, pwrite, smp_valid, smp_irq1, smp_irq2, stall, slow} = 9'h100;
    sys_rst = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    rtc = 32'h0;
    {smp_temp, smp_ext_sensor_input_one, smp_ext_sensor_input_two, smp_batt, smp_ext_sensor_input_one_rng, smp_ext_sensor_input_two_rng} = 46'h0;
    fail_count = 0;
    checked = 0;
    do_reset;
    s_regs;
    s_pack;
    s_dense;
    s_limit;
    s_irq;
    s_fill;
    do_reset;
    s_regs;
    give_verdict;
  end
endmodule // slrf_formatter_bench
